// ### pkg/line_channel_config_consts.vh
// Constants for the per-channel line configuration register bank.
// Assumes inclusion by bare name from the design files under src/.
`ifndef LINE_CHANNEL_CONFIG_CONSTS_VH
`define LINE_CHANNEL_CONFIG_CONSTS_VH

// Register map: offsets within one channel and channel stride
`define CH_CTRL_LINE_OFS 4'h0
`define CH_CTRL_TERM_OFS 4'h1
`define CH_STRIDE 8'h10
`define CH_COUNT 8

// Reset values
`define CH_CTRL_LINE_RST 8'h00
`define CH_CTRL_TERM_RST 8'h00

// First control register fields
`define CABLE_CODE_MSB 4
`define CABLE_CODE_LSB 0

// Termination and jitter control register fields
`define RX_TERM_BIT 7
`define TX_TERM_BIT 6
`define IMP_SEL_MSB 5
`define IMP_SEL_LSB 4
`define JA_PATH_MSB 3
`define JA_PATH_LSB 2
`define JA_BW_BIT 1
`define FIFO_DEPTH_BIT 0

// Cable length codes
`define CODE_T1_BAND0 5'h08
`define CODE_T1_BAND1 5'h09
`define CODE_T1_BAND2 5'h0a
`define CODE_T1_BAND3 5'h0b
`define CODE_T1_BAND4 5'h0c
`define CODE_T1_ARB 5'h0d
`define CODE_E1_COAX 5'h1c
`define CODE_E1_TP 5'h1d

// Transmit pulse setting encodings
`define PULSE_BAND0 3'h0
`define PULSE_BAND1 3'h1
`define PULSE_BAND2 3'h2
`define PULSE_BAND3 3'h3
`define PULSE_BAND4 3'h4
`define PULSE_ARB 3'h5
`define PULSE_G703 3'h6
`define PULSE_NONE 3'h7

// Line impedance select encodings
`define IMP_100 2'h0
`define IMP_110 2'h1
`define IMP_75 2'h2
`define IMP_120 2'h3

// Jitter attenuator path encodings
`define JA_OFF 2'h0
`define JA_TX 2'h1

`endif

// ### src/cable_code_decode.v
// Registered decode of one channel's five-bit cable length code.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "line_channel_config_consts.vh"

module cable_code_decode (
  input wire clk_sys, // System clock
  input wire rst, // Synchronous reset, active high
  input wire [4:0] cableCode, // Cable length code
  output reg modeValid, // Code is a defined line mode
  output reg modeE1, // 1 = E1, 0 = T1
  output reg [2:0] pulseShape, // Transmit pulse setting
  output reg codingHdb3, // 1 = HDB3, 0 = B8ZS
  output reg coaxCable // 1 = 75 ohm coax
);

  reg validD;
  reg e1D;
  reg [2:0] shapeD;
  reg coaxD;

  // Table lookup; undefined codes leave the line unconfigured
  always @* begin
    validD = 1'b1;
    e1D = 1'b0;
    coaxD = 1'b0;
    case (cableCode)
      `CODE_T1_BAND0: shapeD = `PULSE_BAND0;
      `CODE_T1_BAND1: shapeD = `PULSE_BAND1;
      `CODE_T1_BAND2: shapeD = `PULSE_BAND2;
      `CODE_T1_BAND3: shapeD = `PULSE_BAND3;
      `CODE_T1_BAND4: shapeD = `PULSE_BAND4;
      `CODE_T1_ARB: shapeD = `PULSE_ARB;
      `CODE_E1_COAX: begin
        shapeD = `PULSE_G703;
        e1D = 1'b1;
        coaxD = 1'b1;
      end
      `CODE_E1_TP: begin
        shapeD = `PULSE_G703;
        e1D = 1'b1;
      end
      default: begin
        shapeD = `PULSE_NONE;
        validD = 1'b0;
      end
    endcase
  end

  // Outputs from flops so downstream analog controls see clean levels
  always @(posedge clk_sys) begin
    if (rst) begin
      modeValid <= 1'b0;
      modeE1 <= 1'b0;
      pulseShape <= `PULSE_NONE;
      codingHdb3 <= 1'b0;
      coaxCable <= 1'b0;
    end else begin
      modeValid <= validD;
      modeE1 <= e1D;
      pulseShape <= shapeD;
      codingHdb3 <= e1D; // T1 codes use B8ZS, E1 codes HDB3
      coaxCable <= coaxD;
    end
  end

endmodule
`default_nettype wire

// ### src/line_channel_config.v
// Per-channel line configuration registers for an eight-channel line interface.
// Assumes the host port is synchronous to clk_sys and drives one access per cycle.
//
// How it works
// - Cable codes 08-0C pick T1 bands, 0D arbitrary pulse, 1C/1D pick E1.
// - Jitter path field: 00 off, 01 transmit path, 10 and 11 receive path.
// - Reset clears the jitter path field, leaving the attenuator disabled.
// - FIFO depth bit picks 64 or 32 bits for both receive and transmit Jitter_fifo_depth_select.
// - Cable length code sits in bits 4..0 of each first control register.
// - Channels one to seven repeat channel zero's registers every 0x10.
`timescale 1ns/10ps
`default_nettype none
`include "line_channel_config_consts.vh"

module line_channel_config (
  input wire clk_sys, // System clock, 20 MHz
  input wire rst, // Synchronous reset, active high
  input wire [7:0] hostAddr, // Register address
  input wire [7:0] hostWrData, // Write data
  input wire hostWrEn, // Write strobe, one cycle
  input wire hostRdEn, // Read strobe, one cycle
  output reg [7:0] hostRdData, // Read data, valid cycle after strobe
  output reg hostRdValid, // Read data valid pulse
  output wire [7:0] lineModeValid, // Per channel: code is defined
  output wire [7:0] lineModeE1, // Per channel: 1 = E1
  output wire [23:0] txPulseShape, // Per channel: 3-bit pulse setting
  output wire [7:0] lineCodingHdb3, // Per channel: 1 = HDB3
  output wire [7:0] coaxCable, // Per channel: 75 ohm coax
  output wire [15:0] line_impedance_select, // Per channel: impedance code
  output reg [7:0] imp100, // Per channel: 100 ohm termination
  output reg [7:0] imp110, // Per channel: 110 ohm termination
  output reg [7:0] imp75, // Per channel: 75 ohm termination
  output reg [7:0] imp120, // Per channel: 120 ohm termination
  output reg [7:0] jitterTxPath, // Per channel: attenuator in transmit
  output reg [7:0] jitterRxPath, // Per channel: attenuator in receive
  output wire [7:0] jitter_bandwidth_select, // Per channel: bandwidth bit
  output reg [7:0] jitterFifo64, // Per channel: 64-bit FIFO, else 32
  output wire [7:0] receive_termination_select, // Per channel: rx term bit
  output wire [7:0] transmit_termination_select // Per channel: tx term bit
);

  // Channel and register decode of the host address
  wire inChannelSpace;
  wire [2:0] chanSel;
  wire [3:0] regSel;
  wire hitLine;
  wire hitTerm;

  // Flattened copies of every channel's registers for the read path
  wire [63:0] ctrlLineFlat;
  wire [63:0] ctrlTermFlat;

  assign inChannelSpace = ~hostAddr[7];
  assign chanSel = hostAddr[6:4];
  assign regSel = hostAddr[3:0];
  assign hitLine = inChannelSpace && (regSel == `CH_CTRL_LINE_OFS);
  assign hitTerm = inChannelSpace && (regSel == `CH_CTRL_TERM_OFS);

  genvar ch;
  generate
    for (ch = 0; ch < `CH_COUNT; ch = ch + 1) begin : gChan
      reg [7:0] ctrlLine_q;
      reg [7:0] ctrlTerm_q;
      wire wrThis;
      wire [1:0] pathSel;
      wire [1:0] impSel;

      assign wrThis = hostWrEn && (chanSel == ch);

      // Channel registers; every channel resets to the same values
      always @(posedge clk_sys) begin
        if (rst) begin
          ctrlLine_q <= `CH_CTRL_LINE_RST;
          ctrlTerm_q <= `CH_CTRL_TERM_RST;
        end else begin
          if (wrThis && hitLine) begin
            ctrlLine_q <= hostWrData;
          end
          if (wrThis && hitTerm) begin
            ctrlTerm_q <= hostWrData;
          end
        end
      end

      assign ctrlLineFlat[ch*8 +: 8] = ctrlLine_q;
      assign ctrlTermFlat[ch*8 +: 8] = ctrlTerm_q;
      assign pathSel = ctrlTerm_q[`JA_PATH_MSB:`JA_PATH_LSB];
      assign impSel = ctrlTerm_q[`IMP_SEL_MSB:`IMP_SEL_LSB];

      // Field taps straight from the register flops
      assign line_impedance_select[ch*2 +: 2] = impSel;
      assign jitter_bandwidth_select[ch] = ctrlTerm_q[`JA_BW_BIT];
      assign receive_termination_select[ch] = ctrlTerm_q[`RX_TERM_BIT];
      assign transmit_termination_select[ch] = ctrlTerm_q[`TX_TERM_BIT];

      // Decoded controls registered, one cycle behind the field
      always @(posedge clk_sys) begin
        if (rst) begin
          jitterTxPath[ch] <= 1'b0;
          jitterRxPath[ch] <= 1'b0;
          jitterFifo64[ch] <= 1'b0;
          imp100[ch] <= 1'b1;
          imp110[ch] <= 1'b0;
          imp75[ch] <= 1'b0;
          imp120[ch] <= 1'b0;
        end else begin
          jitterTxPath[ch] <= (pathSel == `JA_TX);
          jitterRxPath[ch] <= pathSel[1];
          // One bit steers both the receive and transmit FIFO depth
          jitterFifo64[ch] <= ctrlTerm_q[`FIFO_DEPTH_BIT];
          imp100[ch] <= (impSel == `IMP_100);
          imp110[ch] <= (impSel == `IMP_110);
          imp75[ch] <= (impSel == `IMP_75);
          imp120[ch] <= (impSel == `IMP_120);
        end
      end

      // Line mode decode of the cable length code
      cable_code_decode uDecode (
        .clk_sys(clk_sys),
        .rst(rst),
        .cableCode(ctrlLine_q[`CABLE_CODE_MSB:`CABLE_CODE_LSB]),
        .modeValid(lineModeValid[ch]),
        .modeE1(lineModeE1[ch]),
        .pulseShape(txPulseShape[ch*3 +: 3]),
        .codingHdb3(lineCodingHdb3[ch]),
        .coaxCable(coaxCable[ch])
      );
    end
  endgenerate

  // Read path; addresses outside this bank read as zero
  always @(posedge clk_sys) begin
    if (rst) begin
      hostRdData <= 8'h00;
      hostRdValid <= 1'b0;
    end else begin
      hostRdValid <= hostRdEn;
      if (hostRdEn) begin
        if (hitLine) begin
          hostRdData <= ctrlLineFlat[chanSel*8 +: 8];
        end else if (hitTerm) begin
          hostRdData <= ctrlTermFlat[chanSel*8 +: 8];
        end else begin
          hostRdData <= 8'h00;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### verif/host_port_model.sv
// Host side of the register port, one access at a time.
// Assumes calls from a single bench process.
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
  input wire logic clk_sys, // Clock
  output logic [7:0] hostAddr, // Address
  output logic [7:0] hostWrData, // Data
  output logic hostWrEn, // Write
  output logic hostRdEn, // Read
  input wire logic [7:0] hostRdData, // Read data
  input wire logic hostRdValid // Read valid
);
  // Idle bus at time zero
  initial begin
    hostAddr = 8'h00;
    hostWrData = 8'h00;
    hostWrEn = 1'b0;
    hostRdEn = 1'b0;
  end
  // Released lines invert so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    hostAddr = a;
    hostWrData = d;
    hostWrEn = 1'b1;
    @(posedge clk_sys);
    #2;
    hostWrEn = 1'b0;
    hostAddr = ~a;
    hostWrData = ~d;
  endtask
  // Answer stands in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    #2;
    hostAddr = a;
    hostRdEn = 1'b1;
    @(posedge clk_sys);
    #2;
    hostRdEn = 1'b0;
    hostAddr = ~a;
    d = hostRdData;
    v = hostRdValid;
  endtask
endmodule
`default_nettype wire

// ### verif/line_channel_config_properties.sv
// Checker for the channel register bank.
// Assumes a bind onto line_channel_config.
`timescale 1ns/10ps
`default_nettype none
module line_channel_config_properties (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] hostAddr, // Address
  input wire logic [7:0] hostWrData, // Data
  input wire logic hostWrEn, // Write
  input wire logic [23:0] txPulseShape, // Pulse
  input wire logic [7:0] lineModeE1, // E1
  input wire logic [7:0] jitterTxPath, // Tx path
  input wire logic [7:0] jitterRxPath, // Rx path
  input wire logic [7:0] jitterFifo64, // Depth
  input wire logic [15:0] line_impedance_select // Impedance
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Decoded taps trail a write by two edges
  // Channel five is the one the bench walks through all four path codes
  wire wr51 = hostWrEn && hostAddr == 8'h51;
  wire wr00 = hostWrEn && hostAddr == 8'h00;
  ja_tx_a: assert property (
    wr51 |=> ##1 jitterTxPath[5] == ($past(hostWrData[3:2], 2) == 2'h1)) else $error("tx path");
  ja_rx_a: assert property (
    wr51 |=> ##1 jitterRxPath[5] == $past(hostWrData[3], 2)) else $error("rx path");
  // Reset must win even while the bus is active
  ja_reset_a: assert property (disable iff (1'b0)
    rst ##1 rst |=> jitterTxPath == 8'h00 && jitterRxPath == 8'h00) else $error("ja reset");
  fifo_depth_a: assert property (
    wr51 |=> ##1 jitterFifo64[5] == $past(hostWrData[0], 2)) else $error("fifo depth");
  imp_field_a: assert property (
    wr51 |=> line_impedance_select[11:10] == $past(hostWrData[5:4])) else $error("impedance");
  e1_code_a: assert property (
    wr00 && hostWrData == 8'h1c |=> ##1 lineModeE1[0] && txPulseShape[2:0] == 3'h6)
    else $error("e1 code");
  t1_band_a: assert property (
    wr00 && hostWrData == 8'h0a |=> ##1 !lineModeE1[0] && txPulseShape[2:0] == 3'h2)
    else $error("t1 band");
  ch_stride_a: assert property (
    hostWrEn && hostAddr == 8'h71 |=> line_impedance_select[15:14] == $past(hostWrData[5:4]))
    else $error("stride");
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Bench for the channel register bank.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] hostAddr, hostWrData, hostRdData, lineModeValid, lineModeE1, lineCodingHdb3;
  logic [7:0] coaxCable, imp100, imp110, imp75, imp120, jitterTxPath, jitterRxPath;
  logic [7:0] jitterFifo64, jitter_bandwidth_select, d;
  logic [7:0] receive_termination_select, transmit_termination_select;
  logic [23:0] txPulseShape;
  logic [15:0] line_impedance_select;
  logic hostWrEn, hostRdEn, hostRdValid, v;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  logic [4:0] codes [9] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h1c, 5'h1d, 5'h0e};
  line_channel_config dut (.clk_sys, .rst, .hostAddr, .hostWrData, .hostWrEn, .hostRdEn,
    .hostRdData, .hostRdValid, .lineModeValid, .lineModeE1, .txPulseShape, .lineCodingHdb3,
    .coaxCable, .line_impedance_select, .imp100, .imp110, .imp75, .imp120, .jitterTxPath,
    .jitterRxPath, .jitter_bandwidth_select, .jitterFifo64, .receive_termination_select,
    .transmit_termination_select);
  host_port_model host (.clk_sys, .hostAddr, .hostWrData, .hostWrEn, .hostRdEn, .hostRdData,
    .hostRdValid);
  always #25 clk_sys = ~clk_sys;
  task automatic end_of_test;
    $display("Errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard, far above the roughly 120 cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    #2;
    rst = 1'b0;
    `CHK({imp100, jitterTxPath, jitterRxPath, jitterFifo64}, 32'hff000000)
    // Defaults first, then distinct values per channel to catch aliasing
    for (int n = 0; n < 8; n++) begin
      host.rd(8'(n * 16), d, v);
      `CHK({v, d}, 9'h100)
      host.rd(8'(n * 16 + 1), d, v);
      `CHK({v, d}, 9'h100)
      host.wr(8'(n * 16 + 1), 8'(n * 17) ^ 8'h80);
    end
    for (int n = 0; n < 8; n++) begin
      host.rd(8'(n * 16 + 1), d, v);
      `CHK(d, 8'(n * 17) ^ 8'h80)
      `CHK(line_impedance_select[n * 2 +: 2], 2'(n))
    end
    foreach (codes[i]) begin
      host.wr(8'h00, {3'h0, codes[i]});
      @(posedge clk_sys);
      #2;
      `CHK({lineModeE1[0], lineCodingHdb3[0]}, {2{codes[i][4]}})
      `CHK({coaxCable[0], lineModeValid[0]}, {codes[i] == 5'h1c, codes[i] != 5'h0e})
      `CHK(txPulseShape[2:0], codes[i] < 5'h0e ? 3'(codes[i] - 5'h08) : 3'h6 | {2'h0, !codes[i][4]})
    end
    for (int j = 0; j < 4; j++) begin
      host.wr(8'h51, {2'b10, 2'(j), 2'(j), 1'b1, j[0]});
      @(posedge clk_sys);
      #2;
      `CHK({jitterTxPath[5], jitterRxPath[5]}, {j == 1, j > 1})
      `CHK(jitterFifo64[5], j[0])
      `CHK({imp120[5], imp75[5], imp110[5], imp100[5]}, 4'(1 << j))
      `CHK({receive_termination_select[5], transmit_termination_select[5], jitter_bandwidth_select[5]}, 3'h5)
    end
    // Mid-run reset must drop every setting written above
    @(posedge clk_sys);
    #2;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #2;
    rst = 1'b0;
    `CHK({jitterTxPath, jitterRxPath, jitterFifo64}, 24'h000000)
    `CHK({imp100, imp120, line_impedance_select}, {8'hff, 8'h00, 16'h0000})
    `CHK({lineModeValid, txPulseShape}, {8'h00, 24'hffffff})
    // Global space must not alias onto channel zero
    host.wr(8'h81, 8'h5a);
    host.rd(8'h81, d, v);
    `CHK({v, d}, 9'h100)
    host.rd(8'h01, d, v);
    `CHK(d, 8'h00)
    end_of_test();
  end
endmodule
bind line_channel_config line_channel_config_properties chk (.clk_sys, .rst, .hostAddr,
  .hostWrData, .hostWrEn, .txPulseShape, .lineModeE1, .jitterTxPath, .jitterRxPath,
  .jitterFifo64, .line_impedance_select);
`default_nettype wire
